// File: include/pov_pkg.sv
// Purpose: Shared constants and carriers for the port override block
// Assumes: Register indexes are word indexes, byte address is four times the index
// Notes:   Fuse bits read 0 when programmed
// ====================================================================
// Register map
package pov_pkg;
  localparam logic [7:0] PIN_A_IDX    = 8'h19;
  localparam logic [7:0] DIR_A_IDX    = 8'h1a;
  localparam logic [7:0] LAT_A_IDX    = 8'h1b;
  localparam logic [7:0] CORE_CTL_IDX = 8'h35;
  localparam logic [7:0] NO_REG_IDX   = 8'hff;
  localparam logic [7:0] DIR_A_RST    = 8'h00;
  localparam logic [7:0] LAT_A_RST    = 8'h00;
  localparam logic [7:0] CORE_CTL_RST = 8'h00;
  // Bits 1:0 of the core control word are read-only zero
  localparam logic [7:0] CORE_CTL_WMASK = 8'hfc;
  localparam int         PUD_BIT      = 6;
  localparam logic [3:0] CLKOUT_PIN   = 4'h4;

  // ==================================================================
  // Carriers
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic direction_override_en;
    logic direction_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic input_enable_override_en;
    logic input_enable_override_val;
  } pov_ovr_s;

  typedef struct packed {
    logic extClockSel;
    logic crystalSel;
    logic lfCrystalSel;
    logic sysclkOutFuse;
    logic resetPinDisFuse;
    logic debugLinkFuse;
    logic lockBitsUnprog;
  } pov_fuse_s;

  typedef struct packed {
    logic       cmpAOut;
    logic       cmpAEn;
    logic       extIrqZeroEn;
    logic       pcGroup1En;
    logic [3:0] pcMask;
    logic       debugTransmit;
    logic       pwrDown;
  } pov_alt_s;
endpackage

// File: verilog/pov_port_ctrl.sv
// Purpose: Pin override logic for the secondary port and primary port registers
// Assumes: Fuse and alternate-function inputs come from logic on clk
// Notes:   Pin controls are registered, so they follow their causes by one cycle
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
// What this block does
// R01 - Bit 0 of the secondary port is the clock pin for every source but the internal RC.
// R02 - Bit 1 is taken by the oscillator only when a crystal source is selected.
// R03 - Secondary bits 0 to 3 feed pin change sources 8 to 11 of group 1.
// R04 - Software sets the bit 2 direction to output before the compare A wave can appear.
// R05 - With the clock output fuse programmed bit 2 drives the system clock regardless.
// R06 - That clock keeps running on bit 2 while the chip is in reset.
// R07 - As reset input bit 3 has its pull-up on while the global pull-up off bit is clear, and its driver and digital input off.
// R08 - With the debug fuse programmed and locks open bit 3 is an open-drain link pin.
// R09 - Reset disable or debug active force bit 3 value 0, debug direction, and pull-up on while the global pull-up off bit is clear.
// R10 - Bit 2 value is the clock with clock output, else the compare A output when compare A is enabled, else the latch.
// R11 - Bit 2 digital input stays on for external irq 0 or source 10 with group 1.
// R12 - External clock or crystal forces bit 0 pull-up, direction and value to 0.
// R13 - Crystal selected means crystal or low-frequency crystal; bit 1 is forced to 0.
// R14 - The global pull-up off bit turns off all port pull-ups.
// R15 - Each asserted override enable replaces the normal control by its value.
module pov_port_ctrl (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              chipResetReq,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire pov_pkg::pov_fuse_s fuse,
  input  wire pov_pkg::pov_alt_s  alt,
  input  wire logic [3:0]        pbLatch,
  input  wire logic [3:0]        pbDir,
  input  wire logic [3:0]        pbPinIn,
  output logic      [3:0]        pbOut,
  output logic      [3:0]        pbOe,
  output logic      [3:0]        pbPullup,
  output logic      [3:0]        pbInEn,
  output logic      [3:0]        pinChangeSrc,
  input  wire logic [7:0]        paPinIn,
  output logic      [7:0]        paOut,
  output logic      [7:0]        paOe,
  output logic      [7:0]        paPullup
);
  // ==================================================================
  // Pin synchronisers
  logic [7:0] paMeta_q, paSync_q;
  logic [3:0] pbMeta_q, pbSync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      paMeta_q <= 8'h00;
      paSync_q <= 8'h00;
      pbMeta_q <= 4'h0;
      pbSync_q <= 4'h0;
    end else begin
      paMeta_q <= paPinIn;
      paSync_q <= paMeta_q;
      pbMeta_q <= pbPinIn;
      pbSync_q <= pbMeta_q;
    end
  end

  // ==================================================================
  // AHB-Lite slave
  logic [7:0]  dirA_q, dirA_d, latA_q, latA_d, core_q, core_d;
  logic [7:0]  wrIdx_q, wrIdx_d, aIdx;
  logic        wrPend_q, wrPend_d, addrPhase, aHit;
  logic [31:0] rdata_d;

  always_comb begin
    dirA_d    = dirA_q;
    latA_d    = latA_q;
    core_d    = core_q;
    wrIdx_d   = wrIdx_q;
    wrPend_d  = 1'b0;
    rdata_d   = 32'h0000_0000;
    addrPhase = hsel && hready && htrans[1];
    aIdx      = haddr[9:2];
    aHit      = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    if (wrPend_q) begin
      case (wrIdx_q)
        pov_pkg::DIR_A_IDX:    dirA_d = hwdata[7:0];
        pov_pkg::LAT_A_IDX:    latA_d = hwdata[7:0];
        // Writing ones to the input word flips the matching latch bits
        pov_pkg::PIN_A_IDX:    latA_d = latA_q ^ hwdata[7:0];
        pov_pkg::CORE_CTL_IDX: core_d = hwdata[7:0] & pov_pkg::CORE_CTL_WMASK;
        default: ;
      endcase
    end
    if (chipResetReq) begin
      dirA_d = pov_pkg::DIR_A_RST;
      latA_d = pov_pkg::LAT_A_RST;
      core_d = pov_pkg::CORE_CTL_RST;
    end
    if (addrPhase) begin
      wrPend_d = hwrite;
      wrIdx_d  = aHit ? aIdx : pov_pkg::NO_REG_IDX;
    end
    // Reads use next values so a write just ahead is seen
    if (addrPhase && !hwrite && aHit) begin
      case (aIdx)
        pov_pkg::PIN_A_IDX:    rdata_d = {24'h00_0000, paSync_q};
        pov_pkg::DIR_A_IDX:    rdata_d = {24'h00_0000, dirA_d};
        pov_pkg::LAT_A_IDX:    rdata_d = {24'h00_0000, latA_d};
        pov_pkg::CORE_CTL_IDX: rdata_d = {24'h00_0000, core_d};
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dirA_q    <= pov_pkg::DIR_A_RST;
      latA_q    <= pov_pkg::LAT_A_RST;
      core_q    <= pov_pkg::CORE_CTL_RST;
      wrIdx_q   <= pov_pkg::NO_REG_IDX;
      wrPend_q  <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      dirA_q    <= dirA_d;
      latA_q    <= latA_d;
      core_q    <= core_d;
      wrIdx_q   <= wrIdx_d;
      wrPend_q  <= wrPend_d;
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==================================================================
  // Override decode
  logic pullup_global_off, xtal, clkPin0, rstDis, dbg, sysclk_output_fuse, resetPin;
  logic [3:0] pc;
  pov_pkg::pov_ovr_s ovr [4];
  logic sysTog_q;

  assign pullup_global_off      = core_q[pov_pkg::PUD_BIT];
  assign xtal     = fuse.crystalSel | fuse.lfCrystalSel; // R13
  assign clkPin0  = fuse.extClockSel | xtal; // R01
  assign rstDis   = ~fuse.resetPinDisFuse; // R09
  assign dbg      = ~fuse.debugLinkFuse & fuse.lockBitsUnprog; // R08
  assign sysclk_output_fuse    = ~fuse.sysclkOutFuse;
  assign resetPin = ~rstDis & ~dbg;
  assign pc       = alt.pcMask & {4{alt.pcGroup1En}};

  always_comb begin
    // R12
    ovr[0] = '{pullup_override_en: clkPin0, pullup_override_val: 1'b0, direction_override_en: clkPin0, direction_override_val: 1'b0,
               outval_override_en: clkPin0, outval_override_val: 1'b0, input_enable_override_en: clkPin0 | pc[0],
               input_enable_override_val: (fuse.extClockSel & alt.pwrDown) |
                      (fuse.extClockSel & xtal & pc[0])};
    // R02 R13
    ovr[1] = '{pullup_override_en: xtal, pullup_override_val: 1'b0, direction_override_en: xtal, direction_override_val: 1'b0,
               outval_override_en: xtal, outval_override_val: 1'b0, input_enable_override_en: xtal | pc[1],
               input_enable_override_val: xtal & pc[1]};
    // R05 R10 R11
    ovr[2] = '{pullup_override_en: sysclk_output_fuse, pullup_override_val: 1'b0, direction_override_en: sysclk_output_fuse, direction_override_val: 1'b1,
               outval_override_en: sysclk_output_fuse | alt.cmpAEn,
               outval_override_val: sysclk_output_fuse ? sysTog_q : alt.cmpAOut,
               input_enable_override_en: pc[2] | alt.extIrqZeroEn,
               input_enable_override_val: pc[2] | alt.extIrqZeroEn};
    if (resetPin) begin
      // R07
      ovr[3] = '{pullup_override_en: 1'b1, pullup_override_val: 1'b1, direction_override_en: 1'b1, direction_override_val: 1'b0,
                 outval_override_en: 1'b1, outval_override_val: 1'b0, input_enable_override_en: 1'b1, input_enable_override_val: 1'b0};
    end else begin
      // R08 R09
      ovr[3] = '{pullup_override_en: 1'b1, pullup_override_val: 1'b1, direction_override_en: 1'b1,
                 direction_override_val: dbg & alt.debugTransmit,
                 outval_override_en: 1'b1, outval_override_val: 1'b0, input_enable_override_en: 1'b1,
                 input_enable_override_val: dbg | (rstDis & pc[3])};
    end
  end

  // ==================================================================
  // Secondary port pin controls
  logic [3:0] pbOut_d, pbOe_d, pbPull_d, pbInEn_d;
  for (genvar i = 0; i < 4; i++) begin : g_pin
    // R15
    assign pbPull_d[i] = ovr[i].pullup_override_en ? ovr[i].pullup_override_val : (~pbDir[i] & pbLatch[i] & ~pullup_global_off);
    assign pbOe_d[i]   = ovr[i].direction_override_en ? ovr[i].direction_override_val : pbDir[i];
    assign pbOut_d[i]  = ovr[i].outval_override_en ? ovr[i].outval_override_val : pbLatch[i];
    assign pbInEn_d[i] = ovr[i].input_enable_override_en ? ovr[i].input_enable_override_val : 1'b1;
  end

  // The clock copy runs at half rate; it is cleared only by rst_n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysTog_q <= 1'b0;
    end else begin
      sysTog_q <= ~sysTog_q; // R06
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbOut        <= 4'h0;
      pbOe         <= 4'h0;
      pbPullup     <= 4'h0;
      pbInEn       <= 4'h0;
      pinChangeSrc <= 4'h0;
      paOut        <= 8'h00;
      paOe         <= 8'h00;
      paPullup     <= 8'h00;
    end else if (chipResetReq) begin
      // Pins float in reset, except the clock output on bit 2
      pbOut        <= pbOut_d & pov_pkg::CLKOUT_PIN & {4{sysclk_output_fuse}}; // R06
      pbOe         <= pov_pkg::CLKOUT_PIN & {4{sysclk_output_fuse}}; // R06
      pbPullup     <= 4'h0;
      pbInEn       <= 4'h0;
      pinChangeSrc <= 4'h0;
      paOut        <= 8'h00;
      paOe         <= 8'h00;
      paPullup     <= 8'h00;
    end else begin
      pbOut        <= pbOut_d;
      pbOe         <= pbOe_d;
      pbPullup     <= pbPull_d & {4{~pullup_global_off}}; // R14
      pbInEn       <= pbInEn_d;
      pinChangeSrc <= pbSync_q & pbInEn_d; // R03
      paOut        <= latA_q;
      paOe         <= dirA_q;
      paPullup     <= ~dirA_q & latA_q & {8{~pullup_global_off}}; // R14
    end
  end

  // ==================================================================
  // Checks
  a_bit0_clkpin: assert property (@(posedge clk) disable iff (!rst_n) // R01
    clkPin0 && !chipResetReq |=> !pbOe[0] && !pbOut[0] && !pbPullup[0])
    else $error("bit 0 not held as clock pin");
  a_bit1_gpio: assert property (@(posedge clk) disable iff (!rst_n) // R02
    !xtal && !chipResetReq |=> pbOe[1] == $past(pbDir[1]) && pbOut[1] == $past(pbLatch[1]))
    else $error("bit 1 not ordinary io");
  a_bit1_xtal: assert property (@(posedge clk) disable iff (!rst_n) // R13
    xtal && !chipResetReq |=> !pbOe[1] && !pbOut[1] && !pbPullup[1])
    else $error("bit 1 not forced by crystal");
  a_pc_route: assert property (@(posedge clk) disable iff (!rst_n) // R03
    !chipResetReq && !$past(chipResetReq) |-> pinChangeSrc == ($past(pbSync_q) & pbInEn))
    else $error("pin change source mismatch");
  a_clkout_toggle: assert property (@(posedge clk) disable iff (!rst_n) // R05
    sysclk_output_fuse ##1 sysclk_output_fuse |=> pbOe[2] && pbOut[2] != $past(pbOut[2]))
    else $error("clock not driven on bit 2");
  a_clkout_reset: assert property (@(posedge clk) disable iff (!rst_n) // R06
    sysclk_output_fuse && chipResetReq |=> pbOe[2] && pbOut[2] == $past(sysTog_q))
    else $error("clock lost during reset");
  a_cmp_value: assert property (@(posedge clk) disable iff (!rst_n) // R10
    !sysclk_output_fuse && alt.cmpAEn && !chipResetReq |=> pbOut[2] == $past(alt.cmpAOut))
    else $error("compare output not on bit 2");
  a_bit2_inen: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (alt.extIrqZeroEn || pc[2]) && !chipResetReq |=> pbInEn[2])
    else $error("bit 2 input disabled");
  a_reset_pin: assert property (@(posedge clk) disable iff (!rst_n) // R07
    resetPin && !chipResetReq |=> pbPullup[3] == !$past(pullup_global_off) && !pbOe[3] && !pbInEn[3])
    else $error("reset pin setup wrong");
  a_debug_od: assert property (@(posedge clk) disable iff (!rst_n) // R09
    dbg && !chipResetReq |=> !pbOut[3] && pbOe[3] == $past(alt.debugTransmit))
    else $error("debug pin not open drain");
  a_pud_off: assert property (@(posedge clk) disable iff (!rst_n) // R14
    pullup_global_off && !$past(chipResetReq) |=> paPullup == 8'h00 && pbPullup == 4'h0)
    else $error("pull-up on while disabled");
  a_ovr_dir: assert property (@(posedge clk) disable iff (!rst_n) // R15
    !ovr[0].direction_override_en && !chipResetReq |=> pbOe[0] == $past(pbDir[0]))
    else $error("normal direction not used");

  c_crystal: cover property (@(posedge clk) disable iff (!rst_n) xtal ##1 pbOe == 4'h0);
  c_clkout: cover property (@(posedge clk) disable iff (!rst_n) sysclk_output_fuse ##2 pbOut[2]);
  c_debug_tx: cover property (@(posedge clk) disable iff (!rst_n) dbg ##1 pbOe[3]);
  c_pin_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    wrPend_q && wrIdx_q == pov_pkg::PIN_A_IDX);
endmodule

// File: dv/pov_pin_world.sv
// Purpose: Circuitry on the port pins, resolving each pin level
// Assumes: Outside drive beats a pull-up, the block's own driver beats both
// Notes:   A pin that nobody holds wanders every cycle
`timescale 1ns/1ps
// ====================================================================
// Pin world
module pov_pin_world (
  input  wire logic       clk,
  input  wire logic [3:0] pbOut,
  input  wire logic [3:0] pbOe,
  input  wire logic [3:0] pbPullup,
  input  wire logic [3:0] extB,
  input  wire logic [3:0] extBEn,
  input  wire logic [7:0] paOut,
  input  wire logic [7:0] paOe,
  input  wire logic [7:0] extA,
  output logic      [3:0] pbPinIn,
  output logic      [7:0] paPinIn
);
  logic wander = 1'b0;
  // A floating pin must never look like its last level
  always @(posedge clk) wander <= ~wander;
  assign pbPinIn = (pbOe & pbOut) | (~pbOe & extBEn & extB)
                 | (~pbOe & ~extBEn & (pbPullup | {4{wander}}));
  assign paPinIn = (paOe & paOut) | (~paOe & extA);
endmodule

// File: dv/port_override_and_registers_test.sv
// Purpose: Self-checking bench for the port override block
// Assumes: Zero-wait slave, pin controls one cycle behind their causes
// Notes:   Sync plus register settles within four cycles
`timescale 1ns/1ps
// ====================================================================
// Bench
module port_override_and_registers_test;
  localparam logic [31:0] A_PIN = {22'h0, pov_pkg::PIN_A_IDX, 2'h0};
  localparam logic [31:0] A_DIR = {22'h0, pov_pkg::DIR_A_IDX, 2'h0};
  localparam logic [31:0] A_LAT = {22'h0, pov_pkg::LAT_A_IDX, 2'h0};
  localparam logic [31:0] A_CTL = {22'h0, pov_pkg::CORE_CTL_IDX, 2'h0};
  logic               clk, rst_n, chipResetReq, hsel, hwrite, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, rdv;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [3:0]         pbLatch, pbDir, pbPinIn, pbOut, pbOe, pbPullup, pbInEn, pinChg;
  logic [3:0]         extB, extBEn;
  logic [7:0]         paPinIn, paOut, paOe, paPullup, extA;
  pov_pkg::pov_fuse_s fuse;
  pov_pkg::pov_alt_s  alt;
  int                 num_errors = 0, compares = 0, cyc = 0;
  logic [1:0]         clkSel [4] = '{2'h3, 2'h2, 2'h0, 2'h0};

  pov_port_ctrl uut (.clk(clk), .rst_n(rst_n), .chipResetReq(chipResetReq), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fuse(fuse), .alt(alt), .pbLatch(pbLatch), .pbDir(pbDir), .pbPinIn(pbPinIn),
    .pbOut(pbOut), .pbOe(pbOe), .pbPullup(pbPullup), .pbInEn(pbInEn),
    .pinChangeSrc(pinChg), .paPinIn(paPinIn), .paOut(paOut), .paOe(paOe),
    .paPullup(paPullup));
  pov_pin_world world (.clk(clk), .pbOut(pbOut), .pbOe(pbOe), .pbPullup(pbPullup),
    .extB(extB), .extBEn(extBEn), .paOut(paOut), .paOe(paOe), .extA(extA),
    .pbPinIn(pbPinIn), .paPinIn(paPinIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      summarize;
    end
  end

  // ==================================================================
  // Tasks
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, a, wr, 3'h2};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rdv);
    chk(rdv, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic toggles;
    logic a;
    a = pbOut[2];
    @(posedge clk);
    #1;
    // Logical not keeps the expectation one bit wide before it is widened
    chk(pbOut[2], !a);
  endtask

  // ==================================================================
  // Tests
  initial begin
    {rst_n, chipResetReq, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {fuse, alt, pbLatch, pbDir, extB, extBEn, extA} = {7'h0f, 10'h0, 16'h0, 8'h0f};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_DIR, 32'h0);
    rchk(A_LAT, 32'h0);
    rchk(A_CTL, 32'h0);
    xfer(1'b1, A_DIR, 32'ha5, rdv);
    xfer(1'b1, A_LAT, 32'h3c, rdv);
    xfer(1'b1, 32'h70, 32'hff, rdv);
    rchk(32'h70, 32'h0);
    rchk(A_DIR, 32'ha5);
    settle;
    chk(paOe, 8'ha5);
    chk(paOut, 8'h3c);
    chk(paPullup, 8'h18);
    rchk(A_PIN, 32'h2e);
    xfer(1'b1, A_PIN, 32'h0f, rdv);
    rchk(A_LAT, 32'h33);
    xfer(1'b1, A_CTL, 32'hff, rdv);
    rchk(A_CTL, 32'hfc);
    @(posedge clk);
    pbLatch <= 4'hf;
    settle;
    chk(paPullup, 8'h00);
    chk(pbPullup, 4'h0);
    xfer(1'b1, A_CTL, 32'h00, rdv);
    settle;
    chk(pbPullup, 4'hf);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {fuse.extClockSel, fuse.crystalSel, fuse.lfCrystalSel, pbDir} <= {3'(4'h8 >> i), 4'h0};
      settle;
      chk(pbPullup[1:0], clkSel[i]);
      @(posedge clk);
      pbDir <= 4'hf;
      settle;
      chk(pbOe[1:0], clkSel[i]);
      chk(pbOut[1:0], clkSel[i]);
    end
    $display("clock pins done");
    @(posedge clk);
    {fuse, pbDir} <= {7'h07, 4'h0};
    settle;
    chk(pbOe[2], 1'b1);
    toggles;
    @(posedge clk);
    chipResetReq <= 1'b1;
    settle;
    chk(pbOe[2], 1'b1);
    toggles;
    chk(paOe, 8'h0);
    @(posedge clk);
    {chipResetReq, alt.cmpAEn, alt.cmpAOut, fuse, pbLatch} <= {3'h3, 7'h0f, 4'h0};
    pbDir <= 4'h4;
    settle;
    chk(pbOut[2], 1'b1);
    $display("clock output done");
    @(posedge clk);
    {pbDir, pbLatch, alt} <= {8'h88, 10'h0};
    settle;
    chk({pbPullup[3], pbOe[3], pbInEn[3]}, 3'h4);
    @(posedge clk);
    fuse.resetPinDisFuse <= 1'b0;
    settle;
    chk({pbPullup[3], pbOe[3], pbOut[3]}, 3'h4);
    @(posedge clk);
    {fuse.resetPinDisFuse, fuse.debugLinkFuse, alt.debugTransmit} <= 3'h5;
    settle;
    chk({pbPullup[3], pbOe[3], pbOut[3], pbInEn[3]}, 4'hd);
    $display("reset pin done");
    @(posedge clk);
    {fuse, alt, pbDir, pbLatch, extB, extBEn} <= {7'h0f, 10'h080, 8'h0, 8'h55};
    settle;
    chk(pbInEn[2], 1'b1);
    chk({pinChg[2], pinChg[0]}, 2'h3);
    @(posedge clk);
    {alt, extB} <= {10'h054, 4'h1};
    settle;
    // Source 8 enabled under the RC clock turns the bit 0 input off
    chk({pinChg[2], pinChg[0]}, 2'h0);
    chk(pbInEn, 4'h6);
    $display("pin change done");
    summarize;
  end
endmodule
